// [bench/bmtu_mem_model.sv]
// shared memory partner: one word, answers each phase after a set delay, may report failure
// assumes the unit holds memReq and memAddr through both phases of one access
`timescale 1ns/1ps
`default_nettype none
module bmtu_mem_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	input wire logic [15:0] memWriteData,
	input wire logic [1:0] ackDelay,
	input wire logic failMode,
	input wire logic loadWord,
	input wire logic [15:0] loadValue,
	output logic [15:0] memReadData,
	output logic memAck,
	output logic memFail,
	output logic [15:0] word,
	output logic [31:0] readAddr
);
	logic [1:0] waitQ;
	assign memAck = memReq && waitQ == ackDelay;
	// read data only meaningful with the read answer, junk otherwise
	assign memReadData = (memAck && !memWrite) ? word : ~word;
	assign memFail = memAck && memWrite && failMode;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{waitQ, word, readAddr} <= '0;
		end else begin
			waitQ <= (memReq && !memAck) ? waitQ + 2'h1 : 2'h0;
			if (loadWord) begin
				word <= loadValue;
			end else if (memAck && memWrite && !failMode) begin
				word <= memWriteData;
			end
			if (memAck && !memWrite) begin
				readAddr <= memAddr;
			end
		end
	end
endmodule : bmtu_mem_model
`default_nettype wire

// [bench/bmtu_top_checker.sv]
// assertions on the ports of the bit mask test unit
// assumes one clock domain with the asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module bmtu_top_checker
	import bmtu_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic opStart,
	input wire logic [15:0] opWord0,
	input wire logic [15:0] opWord1,
	input wire logic [15:0] opWord2,
	input wire logic highRegPrefix,
	input wire logic regReadStrobe,
	input wire logic [4:0] regReadIndex,
	input wire logic [31:0] regReadData,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	input wire logic [15:0] memWriteData,
	input wire logic [15:0] memReadData,
	input wire logic memAck,
	input wire logic memFail,
	input wire logic busy,
	input wire logic testFlagValid,
	input wire logic testFlag
);
	logic [15:0] w0Q, w1Q, w2Q, rdQ;
	logic [31:0] regQ;
	logic prefQ, strobeQ;
	wire longOp = w0Q[15:8] == OPC_LONG;
	wire absOp = longOp && w0Q[2:0] == SUB_ABS;
	wire rnOp = w0Q[15:8] == OPC_REG_IND && w0Q[4:3] == SUB_REG_IND;
	wire drOp = w0Q[15:8] == OPC_TSTC_DR;
	wire regOp = drOp || (w0Q[15:8] == OPC_TSTC_CTRL && !w0Q[3]);
	wire [15:0] maskQ = longOp ? {w0Q[4:3], w2Q[13:0]} : {w0Q[7:5], w1Q[12:0]};
	wire [15:0] halfQ = w0Q[4] ? regQ[31:16] : regQ[15:0];
	// operation words are kept whenever a start comes while the unit is not busy, even if disabled
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{w0Q, w1Q, w2Q, rdQ, regQ, prefQ, strobeQ} <= '0;
		end else begin
			if (opStart && !busy) begin
				{w0Q, w1Q, w2Q, prefQ} <= {opWord0, opWord1, opWord2, highRegPrefix};
			end
			strobeQ <= regReadStrobe;
			if (strobeQ) begin
				regQ <= regReadData;
			end
			if (memReq && memAck && !memWrite) begin
				rdQ <= memReadData;
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence readDone;
		memReq && memAck && !memWrite;
	endsequence
	sequence writeDone;
		memReq && memAck && memWrite;
	endsequence
	read_first_a: assert property ($rose(memReq) |-> !memWrite)
		else $error("write phase without a read");
	write_follows_a: assert property (readDone |=> memReq && memWrite)
		else $error("read not followed by write");
	set_bits_a: assert property (readDone |=> memWriteData == (rdQ | maskQ))
		else $error("written word is not read word with mask set");
	mem_flag_a: assert property (writeDone |=> testFlagValid &&
		testFlag == ((rdQ & maskQ) == maskQ || $past(memFail)))
		else $error("memory test flag wrong");
	abs_addr_a: assert property ($rose(memReq) && absOp |->
		memAddr == {16'h0, w0Q[7:5], w1Q[12:0]})
		else $error("absolute address wrong");
	reg_ind_a: assert property ($rose(memReq) && rnOp |-> memAddr == regQ)
		else $error("register indirect address wrong");
	reg_index_a: assert property (regReadStrobe |->
		regReadIndex == {w0Q[3], prefQ, w0Q[2:0]})
		else $error("register index wrong");
	dr_test_a: assert property (regReadStrobe && drOp |-> ##3 testFlagValid &&
		testFlag == ((maskQ & halfQ) == 16'h0))
		else $error("register test flag wrong");
	reg_no_mem_a: assert property (busy && regOp |-> !memReq)
		else $error("register test touched memory");
endmodule : bmtu_top_checker
bind bmtu_top bmtu_top_checker chk (.*);
`default_nettype wire

// [bench/bmtu_top_tb.sv]
// self-checking bench for the bit mask test unit
// assumes the memory model and a register file that answers one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module bmtu_top_tb
	import bmtu_pkg::*;
;
	logic clock, arst_n, opStart, highRegPrefix, exceptionModeSelectBit, busWrite, busRead;
	logic regReadStrobe, memReq, memWrite, memAck, memFail, busy, testFlagValid, testFlag;
	logic loadWord, failMode;
	logic [1:0] ackDelay;
	logic [3:0] busAddr;
	logic [4:0] regReadIndex;
	logic [15:0] opWord0, opWord1, opWord2, memReadData, memWriteData, loadValue, word;
	logic [31:0] normalStackPointer, exceptionStackPointer, statusRegNormal, statusRegException;
	logic [31:0] exceptionModeRegister, vectorBase, modifierControlRegister, regReadData;
	logic [31:0] memAddr, busWriteData, busReadData, readAddr;
	int fails, checksDone;
	bmtu_top DUT (.*);
	bmtu_mem_model mem (.*);
	function automatic logic [31:0] reg_val(input logic [4:0] i);
		return {i, 11'h2a4, ~i, 11'h2a4};
	endfunction : reg_val
	always @(posedge clock) regReadData <= regReadStrobe ? reg_val(regReadIndex) : ~regReadData;
	function automatic logic [47:0] enc_long(input logic [2:0] s, input logic [15:0] a, m);
		return {OPC_LONG, a[15:13], m[15:14], s, 3'h1, a[12:0], 2'h2, m[13:0]};
	endfunction : enc_long
	function automatic logic [47:0] enc_two(input logic [7:0] o, input logic [4:0] f,
		input logic [15:0] m);
		return {o, m[15:13], f, 3'h5, m[12:0], 16'h0};
	endfunction : enc_two
	function automatic logic [31:0] ctl_val(input logic [2:0] c, input logic e);
		case (c)
			3'h0: return exceptionModeRegister;
			3'h1: return vectorBase;
			3'h5: return e ? statusRegException : statusRegNormal;
			3'h7: return modifierControlRegister;
			default: return 32'h0;
		endcase
	endfunction : ctl_val
	task automatic check(input logic [31:0] got, exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic check_bit(input logic got, exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		{busAddr, busWriteData, busWrite} <= {a, d, 1'b1};
		@(posedge clock);
		busWrite <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
		{busAddr, busRead} <= {a, 1'b1};
		@(posedge clock);
		busRead <= 1'b0;
		@(negedge clock);
		d = busReadData;
		@(posedge clock);
	endtask : bus_rd
	task automatic kick(input logic [47:0] w);
		{opWord0, opWord1, opWord2, opStart} <= {w, 1'b1};
		@(posedge clock);
		opStart <= 1'b0;
	endtask : kick
	task automatic wait_valid(output logic f);
		int n;
		n = 0;
		do @(negedge clock); while (testFlagValid !== 1'b1 && ++n < 24);
		check_bit(testFlagValid, 1'b1);
		f = testFlag;
		@(posedge clock);
	endtask : wait_valid
	task automatic run_op(input logic [47:0] w, output logic f);
		kick(w);
		wait_valid(f);
	endtask : run_op
	task automatic load(input logic [15:0] v, input logic fl);
		{loadWord, loadValue, failMode} <= {1'b1, v, fl};
		@(posedge clock);
		loadWord <= 1'b0;
	endtask : load
	task automatic mem_case(input logic [47:0] w, input logic [15:0] init, input logic fl, ef,
		input logic [15:0] ew, input logic [31:0] ea);
		logic f;
		load(init, fl);
		run_op(w, f);
		check_bit(f, ef);
		check({16'h0, word}, {16'h0, ew});
		check(readAddr, ea);
	endtask : mem_case
	task automatic t_bus;
		logic [31:0] d;
		logic f;
		bus_rd(OFS_CTRL, d);
		check(d, 32'h1);
		bus_rd(4'h2, d);
		check(d, 32'h0);
		bus_wr(OFS_CTRL, 32'h0);
		kick(enc_two(OPC_TSTC_DR, 5'h0, 16'hffff));
		@(negedge clock);
		check_bit(busy, 1'b0);
		@(posedge clock);
		bus_wr(OFS_CTRL, 32'h1);
		kick(48'hff00_0000_0000);
		repeat (6) @(negedge clock) check_bit(testFlagValid, 1'b0);
		@(posedge clock);
		{ackDelay, highRegPrefix} <= {2'h3, 1'b0};
		load(16'h8000, 1'b0);
		kick(enc_long(SUB_ABS, 16'h0020, 16'h0003));
		@(posedge clock);
		kick(enc_two(OPC_TSTC_DR, 5'h0, 16'hffff));
		wait_valid(f);
		check_bit(f, 1'b0);
		check({16'h0, word}, 32'h8003);
		ackDelay <= 2'h0;
	endtask : t_bus
	task automatic t_abs;
		mem_case(enc_long(SUB_ABS, 16'h000c, 16'h4238), 16'h5678, 1'b0, 1'b1, 16'h5678, 32'hc);
		mem_case(enc_long(SUB_ABS, 16'hfffe, 16'h8001), 16'h1234, 1'b0, 1'b0, 16'h9235, 32'hfffe);
	endtask : t_abs
	task automatic t_fail;
		logic [31:0] d;
		mem_case(enc_long(SUB_ABS, 16'h0010, 16'h00ff), 16'h00ff, 1'b1, 1'b1, 16'h00ff, 32'h10);
		mem_case(enc_long(SUB_ABS, 16'h0012, 16'h0001), 16'h0000, 1'b1, 1'b1, 16'h0000, 32'h12);
		bus_rd(OFS_FAILCNT, d);
		check(d, 32'h2);
		bus_rd(OFS_STATUS, d);
		check(d, 32'h6);
		bus_rd(OFS_LASTADDR, d);
		check(d, 32'h12);
		bus_wr(OFS_FAILCNT, 32'h0);
		bus_rd(OFS_FAILCNT, d);
		check(d, 32'h0);
	endtask : t_fail
	task automatic t_sp;
		{normalStackPointer, exceptionStackPointer} <= {32'h1000, 32'h2000};
		{exceptionModeSelectBit, ackDelay} <= {1'b1, 2'h2};
		mem_case(enc_two(OPC_SP_MINUS, 5'h1f, 16'h00ff), 16'hff00, 1'b0, 1'b0, 16'hffff, 32'h1fc2);
		{exceptionModeSelectBit, ackDelay} <= {1'b0, 2'h1};
		mem_case(enc_long(SUB_SP_PLUS, 16'hfffc, 16'h00f0), 16'h00f0, 1'b0, 1'b1, 16'h00f0, 32'hffc);
		mem_case(enc_two(OPC_SP_MINUS, 5'h0, 16'h0), 16'h0001, 1'b0, 1'b1, 16'h0001, 32'h1000);
	endtask : t_sp
	task automatic t_rn;
		{highRegPrefix, ackDelay} <= {1'b1, 2'h3};
		mem_case(enc_two(OPC_REG_IND, 5'h0b, 16'h000f), 16'h3, 1'b0, 1'b0, 16'hf, reg_val(5'h1b));
		{highRegPrefix, ackDelay} <= {1'b0, 2'h0};
		mem_case(enc_two(OPC_REG_IND, 5'h08, 16'h8000), 16'h8000, 1'b0, 1'b1, 16'h8000, reg_val(5'h10));
	endtask : t_rn
	task automatic t_regtst;
		logic f;
		logic [31:0] v;
		{exceptionModeRegister, vectorBase, statusRegNormal} <= {32'h10002, 32'h20003, 32'h30000};
		{statusRegException, modifierControlRegister} <= {32'h00001, 32'h30003};
		for (int h = 0; h < 32; h++) begin
			run_op(enc_two(OPC_TSTC_DR, h[4:0], 16'hf800), f);
			v = reg_val({h[3], 1'b0, h[2:0]});
			check_bit(f, ((h[4] ? v[31:16] : v[15:0]) & 16'hf800) == 16'h0);
		end
		for (int k = 0; k < 64; k++) begin
			exceptionModeSelectBit <= k[4];
			run_op(enc_two(OPC_TSTC_CTRL, {k[3], 1'b0, k[2:0]}, {14'h0, k[5], !k[5]}), f);
			v = ctl_val(k[2:0], k[4]);
			check_bit(f, ((k[3] ? v[31:16] : v[15:0]) & {14'h0, k[5], !k[5]}) == 16'h0);
		end
	endtask : t_regtst
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// the whole sequence needs about 600 cycles
	initial begin
		#200us;
		fails++;
		report_and_stop;
	end
	initial begin
		{arst_n, opStart, highRegPrefix, exceptionModeSelectBit, busWrite, busRead} = '0;
		{loadWord, failMode, ackDelay, busAddr, busWriteData, loadValue} = '0;
		{opWord0, opWord1, opWord2, normalStackPointer, exceptionStackPointer} = '0;
		{statusRegNormal, statusRegException, exceptionModeRegister} = '0;
		{vectorBase, modifierControlRegister, fails, checksDone} = '0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		t_bus;
		t_abs;
		t_fail;
		t_sp;
		t_rn;
		t_regtst;
		report_and_stop;
	end
endmodule : bmtu_top_tb
`default_nettype wire

// [rtl/bmtu_field_decode.sv]
// instruction field extraction for the bit mask test unit
// assumes all instruction words are held stable by the caller
`timescale 1ns/1ps
`default_nettype none
module bmtu_field_decode
	import bmtu_pkg::*;
(
	input wire logic [15:0] word0,
	input wire logic [15:0] word1,
	input wire logic [15:0] word2,
	output logic isMemSet,
	output logic isRegTest,
	output logic ctrlOperand,
	output bmtu_mode_e addrMode,
	output logic [15:0] maskImmediate,
	output logic [4:0] shortStackOffset,
	output logic [15:0] longSignedStackOffset,
	output logic [15:0] absoluteAddressField,
	output logic [2:0] addressRegisterField,
	output logic [3:0] operandRegisterField,
	output logic [2:0] controlSelectField,
	output logic highHalf
);
	wire logic isSpMinus = word0[15:8] == OPC_SP_MINUS;
	wire logic isSpPlus = (word0[15:8] == OPC_LONG) && (word0[2:0] == SUB_SP_PLUS);
	wire logic isAbs = (word0[15:8] == OPC_LONG) && (word0[2:0] == SUB_ABS);
	wire logic isRegInd = (word0[15:8] == OPC_REG_IND) && (word0[4:3] == SUB_REG_IND);
	wire logic isCtrl = (word0[15:8] == OPC_TSTC_CTRL) && !word0[3];
	wire logic isDr = word0[15:8] == OPC_TSTC_DR;
	wire logic longForm = isSpPlus || isAbs;
	assign isMemSet = isSpMinus || longForm || isRegInd;
	assign isRegTest = isCtrl || isDr;
	assign ctrlOperand = isCtrl;
	assign addrMode = isSpMinus ? MODE_SP_MINUS : isSpPlus ? MODE_SP_PLUS :
		isRegInd ? MODE_REG_IND : MODE_ABS;
	// mask bits are spread over the first word and the last word
	assign maskImmediate = longForm ? {word0[4:3], word2[13:0]} : {word0[7:5], word1[12:0]};
	assign shortStackOffset = word0[4:0];
	assign longSignedStackOffset = {word0[7:5], word1[12:0]};
	assign absoluteAddressField = {word0[7:5], word1[12:0]};
	assign addressRegisterField = word0[2:0];
	assign operandRegisterField = word0[3:0];
	assign controlSelectField = word0[2:0];
	assign highHalf = word0[4];
endmodule : bmtu_field_decode
`default_nettype wire

// [rtl/bmtu_mask_eval.sv]
// mask arithmetic: set result and the all-set and all-clear tests
// assumes purely combinational use on registered operands
`timescale 1ns/1ps
`default_nettype none
module bmtu_mask_eval (
	input wire logic [15:0] mask,
	input wire logic [15:0] operand,
	output logic [15:0] setValue,
	output logic allSet,
	output logic allClear
);
	assign setValue = operand | mask;
	assign allSet = (mask & ~operand) == 16'h0000;
	assign allClear = (mask & operand) == 16'h0000;
endmodule : bmtu_mask_eval
`default_nettype wire

// [rtl/bmtu_top.sv]
// bit mask test-and-set / test-if-clear execution unit
// assumes memory, register file and core pipeline run on the same clock
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bmtu_top
	import bmtu_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic opStart,
	input wire logic [15:0] opWord0,
	input wire logic [15:0] opWord1,
	input wire logic [15:0] opWord2,
	input wire logic highRegPrefix,
	input wire logic exceptionModeSelectBit,
	input wire logic [31:0] normalStackPointer,
	input wire logic [31:0] exceptionStackPointer,
	input wire logic [31:0] statusRegNormal,
	input wire logic [31:0] statusRegException,
	input wire logic [31:0] exceptionModeRegister,
	input wire logic [31:0] vectorBase,
	input wire logic [31:0] modifierControlRegister,
	output logic regReadStrobe,
	output logic [4:0] regReadIndex,
	input wire logic [31:0] regReadData,
	output logic memReq,
	output logic memWrite,
	output logic [31:0] memAddr,
	output logic [15:0] memWriteData,
	input wire logic [15:0] memReadData,
	input wire logic memAck,
	input wire logic memFail,
	output logic busy,
	output logic testFlagValid,
	output logic testFlag,
	input wire logic [3:0] busAddr,
	input wire logic [31:0] busWriteData,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [31:0] busReadData
);
	bmtu_state_e state_q;
	bmtu_state_e state_d;
	logic [15:0] word0_q;
	logic [15:0] word1_q;
	logic [15:0] word2_q;
	logic prefix_q;
	logic exp_q;
	logic [31:0] operand_q;
	logic [31:0] operand_d;
	logic regReadStrobe_q;
	logic [4:0] regReadIndex_q;
	logic memReq_q;
	logic memReq_d;
	logic memWrite_q;
	logic [31:0] memAddr_q;
	logic [31:0] memAddr_d;
	logic [15:0] memWriteData_q;
	logic testFlagValid_q;
	logic busy_q;
	logic testFlag_q;
	logic testFlag_d;
	logic lastFail_q;
	logic lastFail_d;
	logic enable_q;
	logic [15:0] failCount_q;
	logic [31:0] busReadData_q;

	logic isMemSet;
	logic isRegTest;
	logic ctrlOperand;
	bmtu_mode_e addrMode;
	logic [15:0] maskImmediate;
	logic [4:0] shortStackOffset;
	logic [15:0] longSignedStackOffset;
	logic [15:0] absoluteAddressField;
	logic [2:0] addressRegisterField;
	logic [3:0] operandRegisterField;
	logic [2:0] controlSelectField;
	logic highHalf;
	logic [15:0] setValue;
	logic allSet;
	logic allClear;

	bmtu_field_decode u_decode (
		.word0(word0_q),
		.word1(word1_q),
		.word2(word2_q),
		.isMemSet(isMemSet),
		.isRegTest(isRegTest),
		.ctrlOperand(ctrlOperand),
		.addrMode(addrMode),
		.maskImmediate(maskImmediate),
		.shortStackOffset(shortStackOffset),
		.longSignedStackOffset(longSignedStackOffset),
		.absoluteAddressField(absoluteAddressField),
		.addressRegisterField(addressRegisterField),
		.operandRegisterField(operandRegisterField),
		.controlSelectField(controlSelectField),
		.highHalf(highHalf)
	);

	// register ops test the chosen half, memory ops test the read word
	wire logic [15:0] highHalfValue = operand_q[31:16];
	wire logic [15:0] lowHalfValue = operand_q[15:0];
	wire logic [15:0] evalOperand = (state_q == ST_EVAL) ?
		(highHalf ? highHalfValue : lowHalfValue) : operand_q[15:0];

	bmtu_mask_eval u_eval (
		.mask(maskImmediate),
		.operand(evalOperand),
		.setValue(setValue),
		.allSet(allSet),
		.allClear(allClear)
	);

	// operand address generation
	wire logic [31:0] activeStackPointer = exp_q ? exceptionStackPointer : normalStackPointer;
	wire logic [31:0] shortByteOffset = {26'h0000000, shortStackOffset, 1'b0};
	wire logic [31:0] longByteOffset = {{16{longSignedStackOffset[15]}}, longSignedStackOffset};
	wire logic [31:0] spMinusAddr = activeStackPointer - shortByteOffset;
	wire logic [31:0] spPlusAddr = activeStackPointer + longByteOffset;
	wire logic [31:0] absAddr = {16'h0000, absoluteAddressField};
	wire logic [31:0] directAddr = (addrMode == MODE_SP_MINUS) ? spMinusAddr :
		(addrMode == MODE_SP_PLUS) ? spPlusAddr : absAddr;

	// register index: bit 4 address bank, bit 3 high prefix, low three the number
	wire logic [4:0] addrRegIndex = {1'b1, prefix_q, addressRegisterField};
	wire logic [4:0] drRegIndex = {operandRegisterField[3], prefix_q,
		operandRegisterField[2:0]};
	wire logic needRegRead = (isMemSet && (addrMode == MODE_REG_IND)) ||
		(isRegTest && !ctrlOperand);

	// control register operand; the copy of status follows the mode bit
	wire logic [31:0] statusCopy = exp_q ? statusRegException : statusRegNormal;
	wire logic [31:0] ctrlValue = (controlSelectField == CSEL_EMR) ? exceptionModeRegister :
		(controlSelectField == CSEL_VBA) ? vectorBase :
		(controlSelectField == CSEL_SR) ? statusCopy :
		(controlSelectField == CSEL_MODIFIER_CONTROL_REGISTER) ? modifierControlRegister : 32'h00000000;

	// a start is ignored while busy or while software has the unit disabled
	wire logic startTaken = (state_q == ST_IDLE) && opStart && enable_q;
	wire logic writeDone = (state_q == ST_MEM_WRITE) && memAck;

	always_comb begin
		state_d = state_q;
		operand_d = operand_q;
		memReq_d = memReq_q;
		memAddr_d = memAddr_q;
		testFlag_d = testFlag_q;
		lastFail_d = lastFail_q;
		case (state_q)
			ST_IDLE: begin
				if (startTaken) begin
					state_d = ST_DECODE;
				end
			end
			ST_DECODE: begin
				// unknown opcodes drop back without touching memory or registers
				if (!isMemSet && !isRegTest) begin
					state_d = ST_IDLE;
				end else if (needRegRead) begin
					state_d = ST_REG_WAIT;
				end else if (isMemSet) begin
					memAddr_d = directAddr;
					memReq_d = 1'b1;
					state_d = ST_MEM_READ;
				end else begin
					operand_d = ctrlValue;
					state_d = ST_EVAL;
				end
			end
			ST_REG_WAIT: begin
				state_d = ST_REG_CAP;
			end
			ST_REG_CAP: begin
				if (isMemSet) begin
					memAddr_d = regReadData;
					memReq_d = 1'b1;
					state_d = ST_MEM_READ;
				end else begin
					operand_d = regReadData;
					state_d = ST_EVAL;
				end
			end
			ST_EVAL: begin
				// the register is only read; nothing is written back
				testFlag_d = allClear;
				lastFail_d = 1'b0;
				state_d = ST_DONE;
			end
			ST_MEM_READ: begin
				if (memAck) begin
					operand_d = {16'h0000, memReadData};
					state_d = ST_MEM_WRITE;
				end
			end
			ST_MEM_WRITE: begin
				// the write is attempted even when every selected bit was set
				if (memAck) begin
					memReq_d = 1'b0;
					testFlag_d = allSet || memFail;
					lastFail_d = memFail;
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			operand_q <= 32'h00000000;
			memReq_q <= 1'b0;
			memAddr_q <= 32'h00000000;
			testFlag_q <= 1'b0;
			lastFail_q <= 1'b0;
		end else begin
			state_q <= state_d;
			operand_q <= operand_d;
			memReq_q <= memReq_d;
			memAddr_q <= memAddr_d;
			testFlag_q <= testFlag_d;
			lastFail_q <= lastFail_d;
		end
	end

	// instruction capture at start
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			word0_q <= 16'h0000;
			word1_q <= 16'h0000;
			word2_q <= 16'h0000;
			prefix_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (startTaken) begin
			word0_q <= opWord0;
			word1_q <= opWord1;
			word2_q <= opWord2;
			prefix_q <= highRegPrefix;
			exp_q <= exceptionModeSelectBit;
		end
	end

	// register file read port: strobe one cycle, data the cycle after
	wire logic regReadGo = (state_q == ST_DECODE) && needRegRead;
	wire logic [4:0] regIndexSel = isMemSet ? addrRegIndex : drRegIndex;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regReadStrobe_q <= 1'b0;
			regReadIndex_q <= 5'h00;
		end else begin
			regReadStrobe_q <= regReadGo;
			if (regReadGo) begin
				regReadIndex_q <= regIndexSel;
			end
		end
	end

	// write phase carries the read word with the mask bits forced high
	wire logic readDone = (state_q == ST_MEM_READ) && memAck;
	wire logic [15:0] modifiedWord = memReadData | maskImmediate;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			memWrite_q <= 1'b0;
			memWriteData_q <= 16'h0000;
		end else begin
			if (readDone) begin
				memWrite_q <= 1'b1;
				memWriteData_q <= modifiedWord;
			end else if (writeDone) begin
				memWrite_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			testFlagValid_q <= 1'b0;
		end else begin
			testFlagValid_q <= state_d == ST_DONE;
		end
	end

	// busy looks one state ahead so that the port leaves a flop
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= state_d != ST_IDLE;
		end
	end

	// software port
	wire logic selCtrl = busAddr == OFS_CTRL;
	wire logic selStatus = busAddr == OFS_STATUS;
	wire logic selFailCnt = busAddr == OFS_FAILCNT;
	wire logic selLastAddr = busAddr == OFS_LASTADDR;
	wire logic countFail = writeDone && memFail;
	wire logic clearFail = busWrite && selFailCnt;
	wire logic [15:0] failCountInc = failCount_q + 16'h0001;
	wire logic [31:0] statusWord = {29'h00000000, lastFail_q, testFlag_q,
		state_q != ST_IDLE};
	// unmapped offsets read as zero
	wire logic [31:0] readMux = selCtrl ? {31'h00000000, enable_q} :
		selStatus ? statusWord :
		selFailCnt ? {16'h0000, failCount_q} :
		selLastAddr ? memAddr_q : 32'h00000000;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= CTRL_ENABLE_RST;
			failCount_q <= 16'h0000;
			busReadData_q <= 32'h00000000;
		end else begin
			if (busWrite && selCtrl) begin
				enable_q <= busWriteData[CTRL_ENABLE_BIT];
			end
			// a failure in the clearing cycle still counts
			if (countFail) begin
				failCount_q <= clearFail ? 16'h0001 : failCountInc;
			end else if (clearFail) begin
				failCount_q <= 16'h0000;
			end
			busReadData_q <= busRead ? readMux : 32'h00000000;
		end
	end

	assign regReadStrobe = regReadStrobe_q;
	assign regReadIndex = regReadIndex_q;
	assign memReq = memReq_q;
	assign memWrite = memWrite_q;
	assign memAddr = memAddr_q;
	assign memWriteData = memWriteData_q;
	assign busy = busy_q;
	assign testFlagValid = testFlagValid_q;
	assign testFlag = testFlag_q;
	assign busReadData = busReadData_q;
endmodule : bmtu_top
`default_nettype wire

// [shared/bmtu_pkg.sv]
// constants, opcodes, states and register map of the bit mask test-and-set unit
// assumes one 40 MHz core clock and an active-low asynchronous reset
// Summary of operation
// - memory test-and-set ORs the 16-bit mask into the word, other bits kept
// - memory test-and-set is a read followed by an attempted write
// - test flag set if all mask bits were set or access failed
// - protection, bus lock or foreign write count as failure, memory reports it
// - exception mode bit picks the active stack pointer for stack operands
// - stack-minus address is stack pointer minus short offset in words
// - stack-plus address is stack pointer plus signed 16-bit offset
// - register-indirect address is the address register contents
// - absolute address is a 16-bit unsigned field of the instruction
// - address register field picks 0-7, or 8-15 with high prefix
// - mask is a 16-bit immediate gathered from the instruction words
// - short offset is 5 bits, encoded with a forced zero low bit
// - long offset is sign extended from 16 bits before the add
// - absolute address is gathered from the address bits of the words
// - register test-if-clear sets the flag when mask AND operand is zero
// - register test takes high or low half of control or data/address register
// - exception mode bit picks working mode and status/exception register copy
// - control select: 000 exception mode, 001 vector base, 101 status, 111 modifier
// - operand field 0000-0111 data registers, 1000-1111 address registers
package bmtu_pkg;
	localparam logic [7:0] OPC_SP_MINUS = 8'h06;
	localparam logic [7:0] OPC_LONG = 8'h3e;
	localparam logic [2:0] SUB_SP_PLUS = 3'h3;
	localparam logic [2:0] SUB_ABS = 3'h1;
	localparam logic [7:0] OPC_REG_IND = 8'h16;
	localparam logic [1:0] SUB_REG_IND = 2'h1;
	localparam logic [7:0] OPC_TSTC_CTRL = 8'h14;
	localparam logic [7:0] OPC_TSTC_DR = 8'h0c;
	localparam logic [2:0] CSEL_EMR = 3'h0;
	localparam logic [2:0] CSEL_VBA = 3'h1;
	localparam logic [2:0] CSEL_SR = 3'h5;
	localparam logic [2:0] CSEL_MODIFIER_CONTROL_REGISTER = 3'h7;
	localparam int TEST_FLAG_BIT = 1;
	localparam int EXP_BIT = 18;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_FAILCNT = 4'h8;
	localparam logic [3:0] OFS_LASTADDR = 4'hc;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RST = 1'b1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FLAG_BIT = 1;
	localparam int STAT_FAIL_BIT = 2;
	typedef enum logic [1:0] {
		MODE_SP_MINUS = 2'b00,
		MODE_SP_PLUS = 2'b01,
		MODE_REG_IND = 2'b10,
		MODE_ABS = 2'b11
	} bmtu_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_REG_WAIT = 3'b010,
		ST_REG_CAP = 3'b011,
		ST_EVAL = 3'b100,
		ST_MEM_READ = 3'b101,
		ST_MEM_WRITE = 3'b110,
		ST_DONE = 3'b111
	} bmtu_state_e;
endpackage : bmtu_pkg
